//--- include/sfdp_pkg.sv
// constants and types shared by the parameter-table read logic
package sfdp_pkg;

   // ==========================================================
   // command framing
   // ==========================================================
   localparam logic [7:0] READ_DISCOVERABLE_PARAMS_CMD = 8'h5A;
   localparam int BYTE_BITS = 8;
   localparam int ADDR_BYTES = 3;
   localparam int DUMMY_BYTES = 1;
   localparam int ADDR_BITS = ADDR_BYTES * BYTE_BITS;
   localparam logic [4:0] CMD_LAST_BIT = 5'h07;
   localparam logic [4:0] ADDR_LAST_BIT = 5'h17;
   localparam logic [4:0] DUMMY_LAST_BIT = 5'h07;
   localparam logic [2:0] OUT_FIRST_BIT = 3'h0;
   localparam logic [2:0] OUT_BIT_STEP = 3'h1;
   localparam logic [4:0] BIT_STEP = 5'h01;

   // byte driven when the table feed has nothing ready yet
   localparam logic [7:0] IDLE_BYTE = 8'hFF;

   // ==========================================================
   // timing
   // ==========================================================
   localparam int CLK_MHZ = 250;
   // supply-settle delay in microseconds (plain default)
   localparam int SUPPLY_SETTLE_DELAY_US = 800;
   localparam int SETTLE_CYCLES_DEFAULT =
      SUPPLY_SETTLE_DELAY_US * CLK_MHZ;

   // ==========================================================
   // buffering and table geometry
   // ==========================================================
   localparam int FEED_FIFO_DEPTH = 4;
   localparam int TABLE_DEPTH_DEFAULT = 256;

   // ==========================================================
   // link-side sequencer states
   // ==========================================================
   typedef enum logic [4:0] {
      ST_CMD = 5'b00001,
      ST_ADDR = 5'b00010,
      ST_DUMMY = 5'b00100,
      ST_DATA = 5'b01000,
      ST_IGNORE = 5'b10000
   } link_state_type;

endpackage

//--- src/sfdp_fifo.sv
// small synchronous fifo with valid/ready on both sides and flush
`timescale 1ns/10ps
module sfdp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PTR_W:0] FULL_COUNT = (PTR_W+1)'(DEPTH);
   localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [PTR_W:0] count_reg;
   logic push;
   logic pop;

   // flags from the occupancy count, both forced low while flush is high
   assign in_ready = (count_reg != FULL_COUNT) && !flush;
   assign out_valid = (count_reg != '0) && !flush;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_reg[rd_ptr_reg];

   // storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   // pointers and count; flush empties in one cycle
   always_ff @(posedge clk) begin
      if (!rst_n || flush) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule

//--- src/sfdp_reader.sv
// serial parameter-table read sequencer with power-on state handling
`timescale 1ns/10ps

// Function
// - frame opens with chip select low and opcode 5Ah, fast-read style.
// - three address bytes follow the opcode and set the table start.
// - one dummy byte follows the address, then table data is driven.
// - chip select high at any time ends the read and releases output.
// - after power-up the device sits in standby, not deep power-down.
// - write enable latch is clear after power-up until set again.
// - while power-on reset is asserted, logic is held and commands ignored.
// - read commands are accepted once the settle delay has elapsed.
// - below the write-inhibit threshold operations stop, commands ignored.
module sfdp_reader
   import sfdp_pkg::*;
#(
   parameter int SETTLE_CYCLES = SETTLE_CYCLES_DEFAULT,
   parameter int TABLE_DEPTH = TABLE_DEPTH_DEFAULT,
   parameter int FIFO_DEPTH = FEED_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic si,
   output logic so,
   output logic so_oe,
   input wire logic table_wr_en,
   input wire logic [$clog2(TABLE_DEPTH)-1:0] table_wr_addr,
   input wire logic [BYTE_BITS-1:0] table_wr_data,
   input wire logic latch_set,
   input wire logic latch_clr,
   output logic write_enable_latch,
   output logic in_standby,
   output logic supply_settled
);
   localparam int TAW = $clog2(TABLE_DEPTH);
   localparam int SCW = $clog2(SETTLE_CYCLES + 1);
   localparam logic [SCW-1:0] SETTLE_LAST = SCW'(SETTLE_CYCLES);

   // ==========================================================
   // resets for the link clock domain
   // ==========================================================
   // the host clock stops between frames, so the link side is
   // reset asynchronously by the frame's own select and by the
   // power-on reset; both load constants only
   logic por_active;
   logic link_rst;
   assign por_active = !rst_n;
   assign link_rst = cs_n || por_active;

   // ==========================================================
   // link domain: inbound bit sequencer (rising sclk)
   // ==========================================================
   link_state_type state_reg;
   logic [4:0] bit_cnt_reg;
   logic [ADDR_BITS-1:0] in_shift_reg;
   logic [ADDR_BITS-1:0] link_addr_reg;
   logic req_tgl_reg;
   logic ready_meta_reg;
   logic ready_sync_reg;
   logic [BYTE_BITS-1:0] cmd_byte;
   logic [ADDR_BITS-1:0] addr_word;
   logic addr_done;

   assign cmd_byte = {in_shift_reg[BYTE_BITS-2:0], si};
   assign addr_word = {in_shift_reg[ADDR_BITS-2:0], si};
   assign addr_done = (state_reg == ST_ADDR) &&
                      (bit_cnt_reg == ADDR_LAST_BIT);

   // settle status brought over to the host clock; it is only
   // looked at on the eighth opcode edge, long after it settled
   always_ff @(posedge sclk or posedge por_active) begin
      if (por_active) begin
         ready_meta_reg <= 1'b0;
         ready_sync_reg <= 1'b0;
      end else begin
         ready_meta_reg <= supply_settled;
         ready_sync_reg <= ready_meta_reg;
      end
   end

   // frame sequencer: opcode, address, dummy, then data out
   always_ff @(posedge sclk or posedge link_rst) begin
      if (link_rst) begin
         state_reg <= ST_CMD;
         bit_cnt_reg <= '0;
         in_shift_reg <= '0;
      end else begin
         in_shift_reg <= addr_word;
         case (state_reg)
            ST_CMD: begin
               if (bit_cnt_reg == CMD_LAST_BIT) begin
                  bit_cnt_reg <= '0;
                  // reads only once the supply has settled
                  if (cmd_byte == READ_DISCOVERABLE_PARAMS_CMD &&
                      ready_sync_reg) begin
                     state_reg <= ST_ADDR;
                  end else begin
                     state_reg <= ST_IGNORE;
                  end
               end else begin
                  bit_cnt_reg <= bit_cnt_reg + BIT_STEP;
               end
            end
            ST_ADDR: begin
               if (addr_done) begin
                  bit_cnt_reg <= '0;
                  state_reg <= ST_DUMMY;
               end else begin
                  bit_cnt_reg <= bit_cnt_reg + BIT_STEP;
               end
            end
            ST_DUMMY: begin
               // one dummy byte, bits not looked at
               if (bit_cnt_reg == DUMMY_LAST_BIT) begin
                  bit_cnt_reg <= '0;
                  state_reg <= ST_DATA;
               end else begin
                  bit_cnt_reg <= bit_cnt_reg + BIT_STEP;
               end
            end
            ST_DATA: begin
               // stays here until chip select rises
               bit_cnt_reg <= '0;
            end
            ST_IGNORE: begin
               // unknown opcode, or a read before settling: rest of frame is ignored
               bit_cnt_reg <= '0;
            end
            default: begin
               state_reg <= ST_IGNORE;
               bit_cnt_reg <= '0;
            end
         endcase
      end
   end

   // start address handed to the core with a toggle; the word
   // is held until the next address phase so the core can take
   // it at leisure
   always_ff @(posedge sclk or posedge por_active) begin
      if (por_active) begin
         link_addr_reg <= '0;
         req_tgl_reg <= 1'b0;
      end else if (addr_done) begin
         link_addr_reg <= addr_word;
         req_tgl_reg <= !req_tgl_reg;
      end
   end

   // ==========================================================
   // link domain: outbound shifter (falling sclk)
   // ==========================================================
   logic [BYTE_BITS-1:0] out_shift_reg;
   logic [2:0] out_cnt_reg;
   logic ack_tgl_reg;
   logic hold_meta_reg;
   logic hold_sync_reg;
   logic hold_tgl_reg;
   logic [BYTE_BITS-1:0] hold_byte_reg;
   logic byte_load;
   logic byte_avail;

   assign byte_load = (state_reg == ST_DATA) &&
                      (out_cnt_reg == OUT_FIRST_BIT);
   assign byte_avail = hold_sync_reg != ack_tgl_reg;

   // hold-register toggle synchronised on the falling edge
   always_ff @(negedge sclk or posedge por_active) begin
      if (por_active) begin
         hold_meta_reg <= 1'b0;
         hold_sync_reg <= 1'b0;
      end else begin
         hold_meta_reg <= hold_tgl_reg;
         hold_sync_reg <= hold_meta_reg;
      end
   end

   // acknowledge each byte taken from the hold register
   always_ff @(negedge sclk or posedge por_active) begin
      if (por_active) begin
         ack_tgl_reg <= 1'b0;
      end else if (byte_load && byte_avail) begin
         ack_tgl_reg <= !ack_tgl_reg;
      end
   end

   // bits change on the falling edge so the host samples them on
   // the next rising edge; a late feed gives the idle byte
   always_ff @(negedge sclk or posedge link_rst) begin
      if (link_rst) begin
         out_shift_reg <= IDLE_BYTE;
         out_cnt_reg <= OUT_FIRST_BIT;
      end else if (state_reg == ST_DATA) begin
         out_cnt_reg <= out_cnt_reg + OUT_BIT_STEP;
         if (byte_load) begin
            out_shift_reg <= byte_avail ? hold_byte_reg : IDLE_BYTE;
         end else begin
            out_shift_reg <= {out_shift_reg[BYTE_BITS-2:0], 1'b0};
         end
      end
   end

   // output released the moment chip select rises
   assign so = out_shift_reg[BYTE_BITS-1];
   assign so_oe = (state_reg == ST_DATA) && !link_rst;

   // ==========================================================
   // core domain: synchronisers
   // ==========================================================
   logic cs_meta_reg;
   logic cs_sync_reg;
   logic req_meta_reg;
   logic req_sync_reg;
   logic req_seen_reg;
   logic ack_meta_reg;
   logic ack_sync_reg;
   logic new_req;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cs_meta_reg <= 1'b1;
         cs_sync_reg <= 1'b1;
         req_meta_reg <= 1'b0;
         req_sync_reg <= 1'b0;
         req_seen_reg <= 1'b0;
         ack_meta_reg <= 1'b0;
         ack_sync_reg <= 1'b0;
      end else begin
         cs_meta_reg <= cs_n;
         cs_sync_reg <= cs_meta_reg;
         req_meta_reg <= req_tgl_reg;
         req_sync_reg <= req_meta_reg;
         req_seen_reg <= req_sync_reg;
         ack_meta_reg <= ack_tgl_reg;
         ack_sync_reg <= ack_meta_reg;
      end
   end

   assign new_req = req_sync_reg != req_seen_reg;

   // ==========================================================
   // core domain: power-on settle and state
   // ==========================================================
   logic [SCW-1:0] settle_cnt_reg;
   logic settled_reg;
   logic wel_reg;
   logic standby_reg;

   // reads are refused until the settle count has run out
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         settle_cnt_reg <= '0;
         settled_reg <= 1'b0;
      end else if (!settled_reg) begin
         if (settle_cnt_reg == SETTLE_LAST) begin
            settled_reg <= 1'b1;
         end else begin
            settle_cnt_reg <= settle_cnt_reg + 1'b1;
         end
      end
   end

   // latch clear at power-up; a set in the same cycle as a
   // clear wins, and sets before settling are refused
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wel_reg <= 1'b0;
      end else if (latch_set && settled_reg) begin
         wel_reg <= 1'b1;
      end else if (latch_clr) begin
         wel_reg <= 1'b0;
      end
   end

   // comes up in standby; only a selected frame leaves it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         standby_reg <= 1'b1;
      end else begin
         standby_reg <= cs_sync_reg;
      end
   end

   assign write_enable_latch = wel_reg;
   assign in_standby = standby_reg;
   assign supply_settled = settled_reg;

   // ==========================================================
   // core domain: table, fetch and feed buffer
   // ==========================================================
   logic [BYTE_BITS-1:0] table_mem [TABLE_DEPTH];
   logic [TAW-1:0] fetch_addr_reg;
   logic fetch_active_reg;
   logic [BYTE_BITS-1:0] hold_byte_next;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [BYTE_BITS-1:0] fifo_out_data;
   logic feed_flush;
   logic hold_free;
   logic hold_take;

   // table contents are loaded by the surrounding device
   always_ff @(posedge clk) begin
      if (table_wr_en) begin
         table_mem[table_wr_addr] <= table_wr_data;
      end
   end

   // a deselect drops pending bytes so the next frame starts clean
   assign feed_flush = cs_sync_reg || !rst_n;

   // fetch runs ahead of the shifter until the buffer fills,
   // then stalls on its ready
   always_ff @(posedge clk) begin
      if (!rst_n || cs_sync_reg) begin
         fetch_active_reg <= 1'b0;
         fetch_addr_reg <= '0;
      end else if (new_req) begin
         fetch_active_reg <= 1'b1;
         fetch_addr_reg <= link_addr_reg[TAW-1:0];
      end else if (fetch_active_reg && fifo_in_ready) begin
         fetch_addr_reg <= fetch_addr_reg + 1'b1;
      end
   end

   sfdp_fifo #(
      .WIDTH(BYTE_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_feed (
      .clk(clk),
      .rst_n(rst_n),
      .flush(feed_flush),
      .in_valid(fetch_active_reg),
      .in_ready(fifo_in_ready),
      .in_data(table_mem[fetch_addr_reg]),
      .out_valid(fifo_out_valid),
      .out_ready(hold_take),
      .out_data(fifo_out_data)
   );

   // one byte at a time crosses through the hold register; it is
   // only rewritten after the link side acknowledged the last one
   assign hold_free = hold_tgl_reg == ack_sync_reg;
   assign hold_take = hold_free && fifo_out_valid && !cs_sync_reg;
   assign hold_byte_next = hold_take ? fifo_out_data : hold_byte_reg;

   // on deselect the hold is marked empty against the final ack
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hold_tgl_reg <= 1'b0;
         hold_byte_reg <= IDLE_BYTE;
      end else if (cs_sync_reg) begin
         hold_tgl_reg <= ack_sync_reg;
         hold_byte_reg <= IDLE_BYTE;
      end else begin
         hold_byte_reg <= hold_byte_next;
         if (hold_take) begin
            hold_tgl_reg <= !hold_tgl_reg;
         end
      end
   end
endmodule

//--- verification/sfdp_reader_monitor.sv
// port checks for the parameter-table reader
`timescale 1ns/10ps
module sfdp_reader_monitor #(
   parameter int SETTLE_CYCLES = 20
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic so_oe,
   input wire logic latch_set,
   input wire logic latch_clr,
   input wire logic write_enable_latch,
   input wire logic in_standby,
   input wire logic supply_settled
);
   // ==========================================================
   // helper logic
   // ==========================================================
   // edges spent waiting for the supply; stops once settled
   int unsigned wait_reg;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wait_reg <= 0;
      end else if (!supply_settled) begin
         wait_reg <= wait_reg + 1;
      end
   end
   // ==========================================================
   // properties
   // ==========================================================
   sequence s_deselected;
      cs_n [*6];
   endsequence
   sequence s_selected;
      !cs_n [*6];
   endsequence
   property p_oe_cs;
      @(posedge clk) disable iff (!rst_n) so_oe |-> !cs_n;
   endproperty
   a_oe_cs: assert property (p_oe_cs)
      else $error("output on while deselected");
   property p_oe_settle;
      @(posedge clk) disable iff (!rst_n) so_oe |-> supply_settled;
   endproperty
   a_oe_settle: assert property (p_oe_settle)
      else $error("output before settle");
   // reset itself is the cause here, so it cannot disable this one
   property p_reset_state;
      @(posedge clk) !rst_n |=> !so_oe && !write_enable_latch &&
         in_standby && !supply_settled;
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("bad reset state");
   property p_set;
      @(posedge clk) disable iff (!rst_n)
         supply_settled && latch_set |=> write_enable_latch;
   endproperty
   a_set: assert property (p_set) else $error("latch not set");
   property p_clr;
      @(posedge clk) disable iff (!rst_n)
         !latch_set && latch_clr |=> !write_enable_latch;
   endproperty
   a_clr: assert property (p_clr) else $error("latch not cleared");
   property p_hold;
      @(posedge clk) disable iff (!rst_n)
         !latch_set && !latch_clr |=> $stable(write_enable_latch);
   endproperty
   a_hold: assert property (p_hold) else $error("latch moved alone");
   property p_early;
      @(posedge clk) disable iff (!rst_n)
         !supply_settled |-> !write_enable_latch;
   endproperty
   a_early: assert property (p_early)
      else $error("latch before settle");
   property p_standby;
      @(posedge clk) disable iff (!rst_n) s_deselected |-> in_standby;
   endproperty
   a_standby: assert property (p_standby) else $error("not in standby");
   // a selected frame must take the device out of standby
   property p_active;
      @(posedge clk) disable iff (!rst_n) s_selected |-> !in_standby;
   endproperty
   a_active: assert property (p_active)
      else $error("standby during frame");
   property p_kept;
      @(posedge clk) disable iff (!rst_n) supply_settled |=> supply_settled;
   endproperty
   a_kept: assert property (p_kept) else $error("settle flag dropped");
   property p_late;
      @(posedge clk) disable iff (!rst_n)
         !supply_settled |-> wait_reg <= SETTLE_CYCLES + 2;
   endproperty
   a_late: assert property (p_late) else $error("settle too late");
   property p_soon;
      @(posedge clk) disable iff (!rst_n)
         $rose(supply_settled) |-> wait_reg >= SETTLE_CYCLES - 1;
   endproperty
   a_soon: assert property (p_soon) else $error("settle too soon");
endmodule

bind sfdp_reader sfdp_reader_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES))
   sfdp_reader_monitor_i (.clk(clk), .rst_n(rst_n), .cs_n(cs_n),
   .so_oe(so_oe), .latch_set(latch_set), .latch_clr(latch_clr),
   .write_enable_latch(write_enable_latch), .in_standby(in_standby),
   .supply_settled(supply_settled));

//--- verification/host_model.sv
// serial host model that frames parameter-table reads
`timescale 1ns/10ps
module host_model (
   output logic sclk,
   output logic cs_n,
   output logic si,
   input wire logic so,
   input wire logic so_oe
);
   logic [7:0] rx_bytes [0:7];
   logic oe_seen;
   // link clock rests low and the host stays deselected between frames
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si = 1'b1;
   end
   // opcode, address, dummy, then data_bits clocked at a 64 ns period
   task automatic frame(input logic [7:0] op, input logic [23:0] addr,
      input int data_bits);
      logic [39:0] head;
      head = {op, addr, 8'h00};
      oe_seen = 1'b0;
      for (int i = 0; i < 8; i++) begin
         rx_bytes[i] = 8'h00;
      end
      #21; // deselect gap long enough for the core to flush
      cs_n = 1'b0;
      for (int i = 39; i >= 0; i--) begin
         si = head[i];
         #32 sclk = 1'b1;
         #32 sclk = 1'b0;
      end
      for (int i = 0; i < data_bits; i++) begin
         si = ~si; // idle input toggles so no stale level looks valid
         #32;
         oe_seen = oe_seen | (so_oe === 1'b1);
         // a released line reads back inverted so stale bits show up
         rx_bytes[i / 8] = {rx_bytes[i / 8][6:0],
            (so_oe === 1'b1) ? so : ~so};
         sclk = 1'b1;
         #32 sclk = 1'b0;
      end
      #16 cs_n = 1'b1;
      si = ~si;
   endtask
endmodule

//--- verification/testbench.sv
// self-checking bench for the parameter-table reader
`timescale 1ns/10ps
module testbench
   import sfdp_pkg::*;
;
   localparam int SETTLE = 400;
   logic clk, rst_n, sclk, cs_n, si, so, so_oe, table_wr_en;
   logic latch_set, latch_clr, write_enable_latch, in_standby;
   logic supply_settled;
   logic [7:0] table_wr_addr, table_wr_data;
   int failures, checked;
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   sfdp_reader #(.SETTLE_CYCLES(SETTLE), .TABLE_DEPTH(256),
      .FIFO_DEPTH(FEED_FIFO_DEPTH)) sfdp_reader_i (.clk(clk),
      .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
      .so_oe(so_oe), .table_wr_en(table_wr_en),
      .table_wr_addr(table_wr_addr), .table_wr_data(table_wr_data),
      .latch_set(latch_set), .latch_clr(latch_clr),
      .write_enable_latch(write_enable_latch), .in_standby(in_standby),
      .supply_settled(supply_settled));
   host_model host_model_i (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
      .so_oe(so_oe));
   // ==========================================================
   // shared tasks
   // ==========================================================
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("failures %0d checked %0d", failures, checked);
      if (failures == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // bounded wait, the settle count is the only reason to wait
   task automatic wait_settled;
      for (int n = 0; n < 2 * SETTLE && supply_settled !== 1'b1; n++) begin
         @(posedge clk);
      end
      check(8'(supply_settled), 8'h01);
   endtask
   task automatic latch_pulse(input logic s, input logic c, input logic e);
      @(posedge clk);
      latch_set <= s;
      latch_clr <= c;
      @(posedge clk);
      latch_set <= 1'b0;
      latch_clr <= 1'b0;
      @(posedge clk);
      #1 check(8'(write_enable_latch), 8'(e));
   endtask
   // ==========================================================
   // scenarios
   // ==========================================================
   task automatic s_early;
      latch_pulse(1'b1, 1'b0, 1'b0);
      host_model_i.frame(READ_DISCOVERABLE_PARAMS_CMD, 24'h0, 16);
      check(8'(host_model_i.oe_seen), 8'h00);
      wait_settled();
   endtask
   task automatic s_fill;
      for (int a = 0; a < 256; a++) begin
         @(posedge clk);
         table_wr_en <= 1'b1;
         table_wr_addr <= 8'(a);
         table_wr_data <= 8'(a) ^ 8'h5C;
      end
      @(posedge clk);
      table_wr_en <= 1'b0;
   endtask
   task automatic s_wrap;
      host_model_i.frame(READ_DISCOVERABLE_PARAMS_CMD, 24'h0000FD, 48);
      check(8'(host_model_i.oe_seen), 8'h01);
      for (int i = 0; i < 6; i++) begin
         check(host_model_i.rx_bytes[i], 8'(8'hFD + i) ^ 8'h5C);
      end
      #1 check(8'(so_oe), 8'h00);
   endtask
   task automatic s_wrong_op;
      logic [7:0] ops [0:2];
      ops = '{8'h0B, 8'h5B, 8'hDA};
      for (int i = 0; i < 3; i++) begin
         host_model_i.frame(ops[i], 24'h0, 16);
         check(8'(host_model_i.oe_seen), 8'h00);
      end
   endtask
   task automatic s_cut;
      host_model_i.frame(READ_DISCOVERABLE_PARAMS_CMD, 24'h000010, 12);
      #1 check(8'(so_oe), 8'h00);
      check(host_model_i.rx_bytes[0], 8'h10 ^ 8'h5C);
      check(host_model_i.rx_bytes[1], (8'h11 ^ 8'h5C) >> 4);
      host_model_i.frame(READ_DISCOVERABLE_PARAMS_CMD, 24'h000020, 8);
      check(host_model_i.rx_bytes[0], 8'h20 ^ 8'h5C);
   endtask
   task automatic s_latch;
      latch_pulse(1'b1, 1'b0, 1'b1);
      latch_pulse(1'b0, 1'b1, 1'b0);
      latch_pulse(1'b1, 1'b1, 1'b1);
      latch_pulse(1'b0, 1'b1, 1'b0);
      latch_pulse(1'b1, 1'b0, 1'b1);
   endtask
   // supply dip in mid-run: reset held across a whole frame
   task automatic s_dip;
      @(posedge clk);
      rst_n <= 1'b0;
      host_model_i.frame(READ_DISCOVERABLE_PARAMS_CMD, 24'h0, 16);
      check(8'(host_model_i.oe_seen), 8'h00);
      check(8'(write_enable_latch), 8'h00);
      check(8'(in_standby), 8'h01);
      @(posedge clk);
      rst_n <= 1'b1;
      wait_settled();
      host_model_i.frame(READ_DISCOVERABLE_PARAMS_CMD, 24'h000042, 8);
      check(host_model_i.rx_bytes[0], 8'h42 ^ 8'h5C);
   endtask
   // ==========================================================
   // main sequence and watchdog
   // ==========================================================
   initial begin
      rst_n = 1'b0;
      table_wr_en = 1'b0;
      table_wr_addr = 8'h00;
      table_wr_data = 8'h00;
      latch_set = 1'b0;
      latch_clr = 1'b0;
      failures = 0;
      checked = 0;
      repeat (12) @(posedge clk);
      #1 check({so_oe, write_enable_latch, in_standby, supply_settled},
         8'h02);
      @(posedge clk);
      rst_n <= 1'b1;
      s_early();
      s_fill();
      s_wrap();
      s_wrong_op();
      s_cut();
      s_latch();
      s_dip();
      close_out();
   end
   // whole run is about 36 us; this leaves ample margin
   initial begin
      #120000;
      failures++;
      close_out();
   end
endmodule
